// *** oct_blank_if.sv ***
// blanking timer start and status between control and timer
`timescale 1ns/1ns
interface oct_blank_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport timer (input start, output busy);
endinterface

// *** oct_blank_timer.sv ***
// preloaded down counter that times the fault blanking delay
`timescale 1ns/1ns
`include "oct_defs.svh"
module oct_blank_timer #(
  parameter int BLANK_CYCLES = `OCT_BLANK_CYCLES
) (
  input  wire logic    clk_i,    // core clock
  input  wire logic    resetn_i, // async reset, active low
  oct_blank_if.timer   bi        // start and busy
);
  import oct_pkg::*;
  localparam int CW = $clog2(BLANK_CYCLES + 1);
  localparam logic [CW-1:0] PRELOAD = CW'(BLANK_CYCLES);

  logic [CW-1:0] cnt_reg;

  //--------------------------------------------------------------------
  // counter
  //--------------------------------------------------------------------
  // a new start always reloads, so every select rise restarts blanking
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_reg <= '0;
    else if (bi.start)
      cnt_reg <= PRELOAD;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - CW'(1);
  end

  assign bi.busy = (cnt_reg != '0);

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  property p_preload;
    @(posedge clk_i) disable iff (!resetn_i)
    bi.start |=> (cnt_reg == PRELOAD) ##1 ((cnt_reg == PRELOAD - CW'(1)) || $past(bi.start));
  endproperty
  a_preload: assert property (p_preload) else $error("blanking preload wrong");
endmodule

// *** oct_defs.svh ***
// constants and rule summary of the octal serial driver control
//----------------------------------------------------------------------
// Summary of operation
// - eight serial control bits drive eight channels
// - eight diagnostic bits reflect sensed output levels
// - selected while select low, output floats otherwise
// - select fall loads register from comparators
// - select rise copies register into output latch
// - output on rising clock, input on falling
// - msb first, channel seven leads
// - control zero turns channel on
// - unlimited bits pass through for daisy chains
// - select rise starts blanking, inhibits fault clearing
// - after blanking, overloaded on channels latched off
// - reset clears whole output latch
// - open channel programmed off reads low
// - serial clock ignored while select high
// - reset asynchronous, active low, clears everything but the select synchronisers and the delayed select, which preset high
//----------------------------------------------------------------------
`ifndef OCT_DEFS_SVH
`define OCT_DEFS_SVH

`define OCT_CH_NUM        8
`define OCT_MSB_CH        7
`define OCT_LATCH_RST     8'h00
`define OCT_SHIFT_RST     8'h00
`define OCT_DIAG_RST      8'h00
`define OCT_CLK_PERIOD_NS 4
`define OCT_BLANK_TIME_US 160
`define OCT_BLANK_CYCLES  ((`OCT_BLANK_TIME_US * 1000) / `OCT_CLK_PERIOD_NS)

`endif

// *** oct_driver_ctrl.sv ***
// control logic of the octal serial low-side driver
`timescale 1ns/1ns
`include "oct_defs.svh"
module oct_driver_ctrl #(
  parameter int BLANK_CYCLES = `OCT_BLANK_CYCLES, // blanking length in clk cycles
  parameter int CH_NUM       = `OCT_CH_NUM        // number of channels
) (
  input  wire logic             clk_i,      // core clock, 250 MHz
  input  wire logic             resetn_i,   // async reset, active low
  input  wire logic             sclk_i,     // serial clock from master
  input  wire logic             cs_n_i,     // chip select, active low
  input  wire logic             si_i,       // serial data in
  output logic                  so_o,       // serial data out
  output logic                  so_oe_o,    // serial out enable
  input  wire oct_pkg::oct_byte_t sense_hi_i, // comparators, 1 = pin high
  output oct_pkg::oct_byte_t    drv_on_o,   // 1 = channel stage on
  output logic                  blanking_o  // fault blanking running
);
  import oct_pkg::*;

  //--------------------------------------------------------------------
  // declarations
  //--------------------------------------------------------------------
  // link domain (sclk)
  oct_byte_t  sr_reg;       // shift register, falling edges
  logic       so_reg;       // serial out bit, rising edges
  logic       first_p_reg;  // first rising edge done
  logic       first_n_reg;  // first falling edge done
  logic       link_rst_n;   // clears the frame flags

  // core domain (clk)
  logic       cs_meta_reg;  // select synchroniser stage 1
  logic       cs_sync_reg;  // select synchroniser stage 2
  logic       cs_prev_reg;  // delayed select for edges
  oct_byte_t  sns_meta_reg; // sense synchroniser stage 1
  oct_byte_t  sns_sync_reg; // sense synchroniser stage 2
  oct_byte_t  diag_reg;     // snapshot for the link
  oct_byte_t  latch_on_reg; // parallel output latch
  oct_phase_t phase_reg;    // blanking phase
  oct_phase_t phase_next;
  oct_byte_t  fault_clr;    // per-channel fault clears
  logic       cs_rise;
  logic       cs_fall;

  oct_blank_if blk ();

  //--------------------------------------------------------------------
  // serial pin output
  //--------------------------------------------------------------------
  // pin driver follows the select directly, like the real pad enable
  assign so_oe_o = ~cs_n_i;
  assign so_o    = so_reg;

  //--------------------------------------------------------------------
  // link domain: frame flags
  //--------------------------------------------------------------------
  // select high ends the frame asynchronously; the sclk may stop
  // outside frames, so no edge is needed to rearm the flags
  assign link_rst_n = resetn_i & ~cs_n_i;

  // rising edges: first one shows the channel 7 diagnostic bit
  always_ff @(posedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      first_p_reg <= 1'b0;
    else
      first_p_reg <= 1'b1;
  end

  // falling edges: first one loads the snapshot beneath the new bit
  always_ff @(negedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      first_n_reg <= 1'b0;
    else
      first_n_reg <= first_p_reg;
  end

  //--------------------------------------------------------------------
  // link domain: serial out
  //--------------------------------------------------------------------
  // cs_n is read here without synchronising: the master keeps sclk low
  // around both select edges, so it is quiet at every sclk edge
  always_ff @(posedge sclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      so_reg <= 1'b0;
    else if (!cs_n_i)
    begin
      if (!first_p_reg)
        so_reg <= diag_reg[`OCT_MSB_CH];
      else
        so_reg <= sr_reg[`OCT_MSB_CH];
    end
  end

  //--------------------------------------------------------------------
  // link domain: shift register
  //--------------------------------------------------------------------
  // first falling edge merges the parallel load with the first shift,
  // which is the same as loading at select fall and shifting once;
  // the register is not cleared at select high, so the core can copy it
  always_ff @(negedge sclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sr_reg <= `OCT_SHIFT_RST;
    else if (!cs_n_i)
    begin
      if (!first_n_reg)
        sr_reg <= {diag_reg[`OCT_MSB_CH-1:0], si_i};
      else
        sr_reg <= {sr_reg[`OCT_MSB_CH-1:0], si_i};
    end
  end

  //--------------------------------------------------------------------
  // core domain: synchronisers
  //--------------------------------------------------------------------
  // select passes two flops before the edge detector looks at it
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end
    else
    begin
      cs_meta_reg <= cs_n_i;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  // comparator levels are asynchronous analog results
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sns_meta_reg <= `OCT_DIAG_RST;
      sns_sync_reg <= `OCT_DIAG_RST;
    end
    else
    begin
      sns_meta_reg <= sense_hi_i;
      sns_sync_reg <= sns_meta_reg;
    end
  end

  // select edges in the core domain
  assign cs_fall = cs_prev_reg & ~cs_sync_reg;
  assign cs_rise = ~cs_prev_reg & cs_sync_reg;

  //--------------------------------------------------------------------
  // core domain: diagnostic snapshot
  //--------------------------------------------------------------------
  // taken three clk cycles after select fall and held for the frame;
  // the lead time before the first sclk edge covers this latency, so
  // the word is stable whenever the link domain reads it
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      diag_reg <= `OCT_DIAG_RST;
    else if (cs_fall)
      diag_reg <= sns_sync_reg;
  end

  //--------------------------------------------------------------------
  // core domain: blanking phase
  //--------------------------------------------------------------------
  // every select rise restarts blanking, even from guarding
  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE:
        if (cs_rise)
          phase_next = PH_BLANKING;
      PH_BLANKING:
        if (cs_rise)
          phase_next = PH_BLANKING;
        else if (!blk.busy)
          phase_next = PH_GUARDING;
      PH_GUARDING:
        if (cs_rise)
          phase_next = PH_BLANKING;
      default:
        phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      phase_reg <= PH_IDLE;
    else
      phase_reg <= phase_next;
  end

  // timer restart on each select rise
  assign blk.start  = cs_rise;
  assign blanking_o = (phase_reg == PH_BLANKING);

  oct_blank_timer #(
    .BLANK_CYCLES (BLANK_CYCLES)
  ) u_blank (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .bi       (blk)
  );

  //--------------------------------------------------------------------
  // core domain: fault detection per channel
  //--------------------------------------------------------------------
  // a channel that is on yet still sensed high is overloaded; nothing
  // is cleared while blanking so inrush current can settle
  genvar g;
  generate
    for (g = 0; g < CH_NUM; g++)
    begin : g_fault
      assign fault_clr[g] = (phase_reg == PH_GUARDING)
                          & latch_on_reg[g] & sns_sync_reg[g];
    end
  endgenerate

  //--------------------------------------------------------------------
  // core domain: parallel output latch
  //--------------------------------------------------------------------
  // sr_reg crosses as a quiet word: sclk is stopped low well before
  // select rises and the copy happens three clk cycles later
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      latch_on_reg <= `OCT_LATCH_RST;
    else if (cs_rise)
      latch_on_reg <= ~sr_reg;
    else
      latch_on_reg <= latch_on_reg & ~fault_clr;
  end

  assign drv_on_o = latch_on_reg;

  //--------------------------------------------------------------------
  // checks: sequences
  //--------------------------------------------------------------------
  sequence s_cs_rise;
    cs_rise;
  endsequence

  sequence s_blank_run;
    blk.busy [*8];
  endsequence

  sequence s_guard_fault;
    (phase_reg == PH_GUARDING) && (fault_clr != '0) && !cs_rise;
  endsequence

  //--------------------------------------------------------------------
  // checks: core domain
  //--------------------------------------------------------------------
  property p_latch_load;
    @(posedge clk_i) disable iff (!resetn_i)
    s_cs_rise |=> (latch_on_reg == ~$past(sr_reg));
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("latch not loaded with inverted shift data");

  property p_snapshot;
    @(posedge clk_i) disable iff (!resetn_i)
    cs_fall |=> (diag_reg == $past(sns_sync_reg));
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("diagnostic snapshot not taken at select fall");

  property p_blank_start;
    @(posedge clk_i) disable iff (!resetn_i)
    s_cs_rise |=> s_blank_run and (phase_reg == PH_BLANKING);
  endproperty
  a_blank_start: assert property (p_blank_start)
    else $error("blanking did not start at select rise");

  property p_blank_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    (phase_reg == PH_BLANKING) && !cs_rise |=> $stable(latch_on_reg);
  endproperty
  a_blank_hold: assert property (p_blank_hold)
    else $error("latch changed during blanking");

  property p_fault_clear;
    @(posedge clk_i) disable iff (!resetn_i)
    s_guard_fault |=> ((latch_on_reg & $past(fault_clr)) == '0);
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("overloaded channel not latched off");

  property p_guard_only;
    @(posedge clk_i) disable iff (!resetn_i)
    (phase_reg != PH_GUARDING) |-> (fault_clr == '0);
  endproperty
  a_guard_only: assert property (p_guard_only)
    else $error("fault clear outside guarding");

  // no disable here: the check must hold while reset is low
  property p_reset_clear;
    @(posedge clk_i)
    !resetn_i |-> (latch_on_reg == '0) && (phase_reg == PH_IDLE);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear the output latch");

  //--------------------------------------------------------------------
  // checks: link domain
  //--------------------------------------------------------------------
  property p_so_enable;
    @(posedge sclk_i) disable iff (!resetn_i)
    !cs_n_i |-> so_oe_o ##1 (so_oe_o == !cs_n_i);
  endproperty
  a_so_enable: assert property (p_so_enable)
    else $error("serial out not driven while selected");

  property p_first_bit;
    @(posedge sclk_i) disable iff (!link_rst_n)
    !first_p_reg |=> (so_reg == $past(diag_reg[`OCT_MSB_CH]));
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first serial bit is not channel 7 diagnostic");

  property p_shift_in;
    @(negedge sclk_i) disable iff (!link_rst_n)
    1'b1 |=> (sr_reg[0] == $past(si_i));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial input not captured on falling edge");

  property p_pass_through;
    @(negedge sclk_i) disable iff (!link_rst_n)
    first_n_reg |=> (sr_reg[`OCT_MSB_CH:1] == $past(sr_reg[`OCT_MSB_CH-1:0]));
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("shift register did not shift");

  // a deselected device keeps both link registers frozen
  property p_gate_hold;
    @(posedge sclk_i) disable iff (!resetn_i)
    cs_n_i |=> $stable(sr_reg) && $stable(so_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("link registers moved while deselected");
endmodule

// *** oct_pkg.sv ***
// types shared by the octal serial driver control
package oct_pkg;
  typedef logic [7:0] oct_byte_t;
  typedef enum logic [1:0] {PH_IDLE, PH_BLANKING, PH_GUARDING} oct_phase_t;
endpackage

// *** oct_spi_master.sv ***
// serial bus master model that frames transfers to the driver control
`timescale 1ns/1ns
module oct_spi_master (
  output logic      sclk_o, // serial clock, low outside frames except for stray clocks
  output logic      cs_n_o, // chip select, active low
  output logic      si_o,   // serial data towards the device
  input  wire logic so_i    // resolved serial data from the device
);
  // idle bus: deselected, clock parked low
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // one frame of nbits, msb first; rx gathers the bit seen after each rise
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx     = 16'h0000;
    si_o   = tx[nbits-1]; // leading bit waits before the first clock
    cs_n_o = 1'b0;        // clock is low at the select fall
    #60;
    for (int k = nbits - 1; k >= 0; k--)
    begin
      #13 sclk_o = 1'b1;         // 15 ns low, 15 ns high: 30 ns period
      #14 rx = {rx[14:0], so_i}; // device bit follows the rise
      #1 sclk_o = 1'b0;          // device takes si on this fall
      #2 si_o = (k > 0) ? tx[k-1] : ~si_o; // hold kept, then data moves on
    end
    #60 cs_n_o = 1'b1; // clock still low at the select rise
  endtask

  // stray clocks with the select high, only when a scenario asks for them
  task automatic stray(input int n);
    repeat (n)
    begin
      si_o = ~si_o;
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
  endtask
endmodule

// *** octal_serial_driver_control_tb.sv ***
// self-checking testbench of the octal serial driver control
`timescale 1ns/1ns
module octal_serial_driver_control_tb;
  import oct_pkg::*;
  localparam int BLANK = 20; // short blanking keeps the run brief

  logic        clk_i;
  logic        resetn_i;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so_o;
  logic        so_oe_o;
  logic        blanking_o;
  logic        so_wire;
  oct_byte_t   sense_hi_i;
  oct_byte_t   drv_on_o;
  logic [15:0] rx;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  // a released pin never shows its last level
  assign so_wire = so_oe_o ? so_o : ~so_o;

  oct_driver_ctrl #(.BLANK_CYCLES(BLANK), .CH_NUM(8)) uut (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .sclk_i     (sclk),
    .cs_n_i     (cs_n),
    .si_i       (si),
    .so_o       (so_o),
    .so_oe_o    (so_oe_o),
    .sense_hi_i (sense_hi_i),
    .drv_on_o   (drv_on_o),
    .blanking_o (blanking_o)
  );

  oct_spi_master master (
    .sclk_o (sclk),
    .cs_n_o (cs_n),
    .si_o   (si),
    .so_i   (so_wire)
  );

  // core clock, 4 ns
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // bounded wait on the blanking flag; running out ends the run
  task automatic wait_blank(input logic lvl, input int lim);
    int i;
    i = 0;
    while (blanking_o !== lvl && i < lim)
    begin
      @(negedge clk_i);
      i++;
    end
    if (blanking_o !== lvl)
    begin
      chk(8'(blanking_o), 8'(lvl));
      conclude();
    end
  endtask

  // outputs right after reset
  task automatic t_reset;
    chk(drv_on_o, 8'h00);
    chk(8'(so_oe_o), 8'h00);
    chk(8'(blanking_o), 8'h00);
  endtask

  // one byte: diagnostics out, control into latch, blanking, then fault clear
  task automatic t_byte;
    sense_hi_i = 8'ha5;
    repeat (4) @(negedge clk_i);
    fork
      master.xfer(16'h003c, 8, rx);
      #30 chk(8'(so_oe_o), 8'h01);
    join
    chk(rx[7:0], 8'ha5);
    wait_blank(1'b1, 10);
    chk(drv_on_o, 8'hc3);
    chk(8'(so_oe_o), 8'h00);
    repeat (10) @(negedge clk_i);
    chk(drv_on_o, 8'hc3);
    wait_blank(1'b0, BLANK + 4);
    repeat (5) @(negedge clk_i);
    chk(drv_on_o, 8'h42);
  endtask

  // sixteen bits: the first byte reappears behind the diagnostics
  task automatic t_chain;
    sense_hi_i = 8'h5a;
    repeat (4) @(negedge clk_i);
    master.xfer(16'h12f0, 16, rx);
    chk(rx[15:8], 8'h5a);
    chk(rx[7:0], 8'h12);
    wait_blank(1'b1, 10);
    chk(drv_on_o, 8'h0f);
  endtask

  // clocks with the select high must move nothing
  task automatic t_gate;
    logic s;
    oct_byte_t d;
    wait_blank(1'b0, BLANK + 4);
    repeat (5) @(negedge clk_i);
    s = so_o;
    d = drv_on_o;
    master.stray(4);
    repeat (12) @(negedge clk_i);
    chk(8'(so_o), 8'(s));
    chk(drv_on_o, d);
    chk(8'(blanking_o), 8'h00);
  endtask

  // reset in mid-blanking clears the latch without a clock
  task automatic t_reset_mid;
    sense_hi_i = 8'h00;
    master.xfer(16'h0000, 8, rx);
    wait_blank(1'b1, 10);
    chk(drv_on_o, 8'hff);
    resetn_i = 1'b0;
    #1;
    chk(drv_on_o, 8'h00);
    repeat (2) @(negedge clk_i);
    chk(8'(blanking_o), 8'h00);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(drv_on_o, 8'h00);
  endtask

  // main sequence
  initial
  begin
    resetn_i   = 1'b0;
    sense_hi_i = 8'h00;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_reset();
    t_byte();
    t_chain();
    t_gate();
    t_reset_mid();
    conclude();
  end
endmodule
